/* File: logic/hostbus_host.sv */
`timescale 1ns/1ns
module hostbus_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  hostbus_if.host bus,
  input wire logic mode_16bit,
  input wire logic req_valid,
  output logic req_ready,
  input wire hostbus_pkg::host_op_t req_op,
  input wire logic [10:2] req_addr,
  input wire hostbus_pkg::mid_t req_data,
  output logic rsp_valid_reg,
  output hostbus_pkg::mid_t rsp_data_reg
);
  import hostbus_pkg::*;

  typedef struct packed {
    host_state_t state;
    logic cmd;
    logic wr;
    logic rd;
    logic addr_ten;
    mid_t out;
    mid_t oe_n;
    logic rsp_valid;
    mid_t rsp_data;
  } host_reg_t;

  localparam host_reg_t HOST_RESET = '{
    state: HOST_IDLE,
    cmd: CMD_DATA,
    wr: 1'h0,
    rd: 1'h0,
    addr_ten: 1'h0,
    out: MID_ZERO,
    oe_n: MID_RELEASED,
    rsp_valid: 1'h0,
    rsp_data: MID_ZERO
  };

  host_reg_t state_reg;
  host_reg_t state_next;

  assign req_ready = (state_reg.state == HOST_IDLE);

  always_comb begin
    state_next = state_reg;
    state_next.wr = 1'h0;
    state_next.rd = 1'h0;
    state_next.rsp_valid = 1'h0;
    state_next.out = MID_ZERO;
    state_next.oe_n = MID_RELEASED;
    case (state_reg.state)
      HOST_IDLE: begin
        if (req_valid) begin
          case (req_op)
            OP_ADDR: begin
              // [R8] Address phase
              state_next.cmd = CMD_ADDR;
              state_next.wr = 1'h1;
              state_next.oe_n = MID_ZERO;
              if (mode_16bit) begin
                // [R3] [R4] Full slice of address
                state_next.out = req_addr[MID_HI:MID_LO];
              end else begin
                // [R5] [R9] First write carries address bits 7..2
                state_next.out = {1'h0, req_addr[MID_HI-1:MID_LO]};
                state_next.addr_ten = req_addr[10];
                state_next.state = HOST_ADDR_SECOND;
              end
            end
            OP_DATA_WR: begin
              // [R1] Data on the slice
              state_next.cmd = CMD_DATA;
              state_next.wr = 1'h1;
              state_next.oe_n = MID_ZERO;
              state_next.out = req_data;
            end
            OP_DATA_RD: begin
              state_next.cmd = CMD_DATA;
              state_next.rd = 1'h1;
              state_next.state = HOST_READ_HOLD;
            end
            default: begin
              state_next.state = HOST_IDLE;
            end
          endcase
        end
      end
      HOST_ADDR_SECOND: begin
        // [R7] [R9] Second write: A10 on line 2, rest don't care
        state_next.cmd = CMD_ADDR;
        state_next.wr = 1'h1;
        state_next.oe_n = MID_ZERO;
        state_next.out[ADDR_TEN_LINE] = state_reg.addr_ten;
        state_next.state = HOST_IDLE;
      end
      HOST_READ_HOLD: begin
        // Device registers its drive, so the strobe spans two cycles
        state_next.rd = 1'h1;
        state_next.state = HOST_READ_SAMPLE;
      end
      HOST_READ_SAMPLE: begin
        // [R1] Sample data driven by the device
        state_next.rsp_data = bus.shared_bus_mid;
        if (!mode_16bit) begin
          state_next.rsp_data[MID_HI] = 1'h0;
        end
        state_next.rsp_valid = 1'h1;
        state_next.state = HOST_IDLE;
      end
      default: begin
        state_next.state = HOST_IDLE;
      end
    endcase
    // [R2] Line 8 held at ground in 8-bit mode
    if (!mode_16bit) begin
      state_next.out[MID_HI] = 1'h0;
      state_next.oe_n[MID_HI] = 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= HOST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.cmd_type = state_reg.cmd;
  assign bus.wr_stb = state_reg.wr;
  assign bus.rd_stb = state_reg.rd;
  assign bus.bus_mode = mode_16bit;
  assign bus.host_mid_out = state_reg.out;
  assign bus.host_mid_oe_n = state_reg.oe_n;
  assign rsp_valid_reg = state_reg.rsp_valid;
  assign rsp_data_reg = state_reg.rsp_data;
endmodule // hostbus_host

/* File: include/hostbus_pkg.sv */
package hostbus_pkg;
  // Middle slice of the shared bus: lines 8 down to 2
  localparam int MID_HI = 8;
  localparam int MID_LO = 2;
  localparam int MID_W = 7;
  // Line that carries address bit 10 on the second 8-bit address write
  localparam int ADDR_TEN_LINE = 2;
  // Command-type encoding
  localparam logic CMD_DATA = 1'h0;
  localparam logic CMD_ADDR = 1'h1;
  // Bus mode encoding
  localparam logic MODE_8BIT = 1'h0;
  localparam logic MODE_16BIT = 1'h1;
  // Reset and idle values
  localparam logic [MID_W-1:0] MID_ZERO = 7'h00;
  localparam logic [MID_W-1:0] MID_RELEASED = 7'h7F;
  // Pad pulls of lines 8..2 when nobody drives: a set bit pulls up
  localparam logic [MID_W-1:0] MID_PULL_UP = 7'h58;
  // A read strobe is held this many cycles; the device drives in the last
  localparam int READ_CYCLES = 2;

  typedef logic [MID_HI:MID_LO] mid_t;
  typedef enum logic {ADDR_FIRST, ADDR_SECOND} addr_phase_t;
  typedef enum logic [1:0] {OP_ADDR, OP_DATA_WR, OP_DATA_RD} host_op_t;
  typedef enum logic [1:0] {
    HOST_IDLE, HOST_ADDR_SECOND, HOST_READ_HOLD, HOST_READ_SAMPLE
  } host_state_t;
endpackage

/* File: include/hostbus_if.sv */
`timescale 1ns/1ns
interface hostbus_if;
  import hostbus_pkg::*;
  logic cmd_type;
  logic wr_stb;
  logic rd_stb;
  logic bus_mode;
  hostbus_pkg::mid_t host_mid_out;
  hostbus_pkg::mid_t host_mid_oe_n;
  hostbus_pkg::mid_t dev_mid_out;
  hostbus_pkg::mid_t dev_mid_oe_n;
  hostbus_pkg::mid_t shared_bus_mid;

  // Wire level; a released line settles to its own pad pull, so an
  // ungrounded line 8 reads high
  assign shared_bus_mid = (~host_mid_oe_n & host_mid_out) |
                          (~dev_mid_oe_n & dev_mid_out) |
                          (host_mid_oe_n & dev_mid_oe_n & MID_PULL_UP);

  modport device (
    input cmd_type,
    input wr_stb,
    input rd_stb,
    input bus_mode,
    input shared_bus_mid,
    output dev_mid_out,
    output dev_mid_oe_n
  );
  modport host (
    output cmd_type,
    output wr_stb,
    output rd_stb,
    output bus_mode,
    output host_mid_out,
    output host_mid_oe_n,
    input shared_bus_mid
  );
endinterface

/* File: logic/hostbus_device.sv */
`timescale 1ns/1ns
// Function
// [R1] Command low: lines 8..2 are data; in 8-bit mode the code takes data from lines 7..2 only and reads line 8 as 0
// [R2] Host grounds line 8 in 8-bit mode; host releases it in reset and for a cycle after reset or a switch to 8-bit
// [R3] 16-bit address phase: line 8 is address
// [R4] 16-bit address phase: lines 7..2 address
// [R5] 8-bit first address write: lines 7..2 address
// [R6] 8-bit second address write ignores lines 7..3
// [R7] 8-bit second address write: line 2 is A10
// [R8] Command high marks address phase, low data
// [R9] 8-bit address split over two writes
// [R10] Phase bit toggles per 8-bit address write
module hostbus_device (
  input wire logic clk_sys,
  input wire logic rst_n,
  hostbus_if.device bus,
  input wire hostbus_pkg::mid_t rd_data,
  output hostbus_pkg::mid_t wr_data_reg,
  output logic wr_data_valid_reg,
  output hostbus_pkg::mid_t addr_mid_reg,
  output logic addr_ten_reg,
  output logic addr_valid_reg,
  output hostbus_pkg::addr_phase_t addr_phase_reg
);
  import hostbus_pkg::*;

  typedef struct packed {
    addr_phase_t phase;
    mid_t addr_mid;
    logic addr_ten;
    logic addr_stb;
    mid_t wr_data;
    logic data_stb;
    mid_t drive;
    mid_t drive_oe_n;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{
    phase: ADDR_FIRST,
    addr_mid: MID_ZERO,
    addr_ten: 1'h0,
    addr_stb: 1'h0,
    wr_data: MID_ZERO,
    data_stb: 1'h0,
    drive: MID_ZERO,
    drive_oe_n: MID_RELEASED
  };

  dev_state_t state_reg;
  dev_state_t state_next;
  logic mode_16;

  assign mode_16 = (bus.bus_mode == MODE_16BIT);

  always_comb begin
    state_next = state_reg;
    state_next.addr_stb = 1'h0;
    state_next.data_stb = 1'h0;
    state_next.drive = rd_data;
    state_next.drive_oe_n = MID_RELEASED;
    // [R1] Drive read data
    if (bus.rd_stb && bus.cmd_type == CMD_DATA) begin
      state_next.drive_oe_n = MID_ZERO;
      // [R2] Line 8 unused in 8-bit mode; left to the host's ground
      if (!mode_16) begin
        state_next.drive_oe_n[MID_HI] = 1'h1;
      end
    end
    if (bus.wr_stb) begin
      // [R8] Command type selects data or address
      if (bus.cmd_type == CMD_DATA) begin
        // [R1] Capture data bits
        state_next.wr_data = bus.shared_bus_mid;
        if (!mode_16) begin
          state_next.wr_data[MID_HI] = 1'h0;
        end
        state_next.data_stb = 1'h1;
      end else if (mode_16) begin
        // [R3] [R4] Whole slice is address
        state_next.addr_mid = bus.shared_bus_mid;
        state_next.phase = ADDR_FIRST;
        state_next.addr_stb = 1'h1;
      end else if (state_reg.phase == ADDR_FIRST) begin
        // [R5] [R9] Low address bits first
        state_next.addr_mid[MID_HI-1:MID_LO] =
          bus.shared_bus_mid[MID_HI-1:MID_LO];
        // [R10] Advance to second write
        state_next.phase = ADDR_SECOND;
      end else begin
        // [R6] [R7] Only line 2 counts, as A10
        state_next.addr_ten = bus.shared_bus_mid[ADDR_TEN_LINE];
        // [R10] Back to first write
        state_next.phase = ADDR_FIRST;
        state_next.addr_stb = 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= DEV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.dev_mid_out = state_reg.drive;
  assign bus.dev_mid_oe_n = state_reg.drive_oe_n;
  assign wr_data_reg = state_reg.wr_data;
  assign wr_data_valid_reg = state_reg.data_stb;
  assign addr_mid_reg = state_reg.addr_mid;
  assign addr_ten_reg = state_reg.addr_ten;
  assign addr_valid_reg = state_reg.addr_stb;
  assign addr_phase_reg = state_reg.phase;
endmodule // hostbus_device

/* File: dv/hostbus_assertions.sv */
`timescale 1ns/1ns
module hostbus_assertions
  import hostbus_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_type,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic bus_mode,
  input wire hostbus_pkg::mid_t host_mid_oe_n,
  input wire hostbus_pkg::mid_t dev_mid_oe_n,
  input wire hostbus_pkg::mid_t shared_bus_mid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_read_two_cycles: assert property (
    $rose(rd_stb) |=> rd_stb ##1 !rd_stb) else $error("read length");
  a_read_is_data: assert property (
    rd_stb |-> cmd_type == CMD_DATA) else $error("read not data");
  a_host_off_read: assert property (
    rd_stb |-> host_mid_oe_n[7:2] == 6'h3F) else $error("host drives");
  a_dev_drives_read: assert property (
    $past(rd_stb && cmd_type == CMD_DATA) |-> dev_mid_oe_n[7:2] == 6'h00)
    else $error("device silent");
  a_no_contention: assert property (
    (~host_mid_oe_n & ~dev_mid_oe_n) == MID_ZERO) else $error("clash");
  // Line 8 has a pull-up, so only an active ground keeps it low
  a_line8_grounded: assert property (
    bus_mode == MODE_8BIT && $past(bus_mode == MODE_8BIT) && $past(rst_n)
    |-> !shared_bus_mid[8]) else $error("line 8 high");
  a_dev_line8_off: assert property (
    bus_mode == MODE_8BIT && $past(bus_mode == MODE_8BIT)
    |-> dev_mid_oe_n[8]) else $error("device on line 8");
  a_addr_pair: assert property (
    $rose(wr_stb) && cmd_type && bus_mode == MODE_8BIT
    |=> wr_stb && cmd_type && shared_bus_mid[7:3] == 5'h00)
    else $error("bad second write");
  a_wide_drive: assert property (
    wr_stb && bus_mode == MODE_16BIT |-> host_mid_oe_n == MID_ZERO)
    else $error("wide write undriven");

  c_read: cover property (rd_stb ##1 rd_stb);
  c_addr8: cover property ($rose(wr_stb) && cmd_type && !bus_mode);
  c_addr16: cover property (wr_stb && cmd_type && bus_mode);
endmodule // hostbus_assertions

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED at %0t: mismatch", $time); end end
module tb_top;
  import hostbus_pkg::*;
  typedef struct packed {
    logic m;
    host_op_t op;
    logic [10:2] a;
    mid_t d;
    logic [7:0] e;
  } row_t;
  logic clk_sys, rst_n, mode_16bit, req_valid, req_ready, rsp_valid_reg;
  logic wr_data_valid_reg, addr_ten_reg, addr_valid_reg;
  host_op_t req_op;
  logic [10:2] req_addr;
  mid_t req_data, rd_data, rsp_data_reg, wr_data_reg, addr_mid_reg;
  addr_phase_t addr_phase_reg;
  logic [7:0] got;
  int fails = 0;
  int check_count = 0;
  // Expected word: bit 7 is address bit 10 on 8-bit address rows
  row_t rows [8] = '{
    '{1'b1, OP_ADDR, 9'h1AB, 7'h00, 8'h2B},
    '{1'b1, OP_DATA_WR, 9'h000, 7'h55, 8'h55},
    '{1'b1, OP_DATA_RD, 9'h000, 7'h7F, 8'h7F},
    '{1'b1, OP_ADDR, 9'h140, 7'h00, 8'h40},
    '{1'b0, OP_ADDR, 9'h1FC, 7'h00, 8'hBC},
    '{1'b0, OP_ADDR, 9'h003, 7'h00, 8'h03},
    '{1'b0, OP_DATA_WR, 9'h000, 7'h7F, 8'h3F},
    '{1'b0, OP_DATA_RD, 9'h000, 7'h6A, 8'h2A}};

  hostbus_if bus ();
  hostbus_device hostbus_device_inst (.clk_sys, .rst_n, .bus, .rd_data,
    .wr_data_reg, .wr_data_valid_reg, .addr_mid_reg, .addr_ten_reg,
    .addr_valid_reg, .addr_phase_reg);
  hostbus_host hostbus_host_inst (.clk_sys, .rst_n, .bus, .mode_16bit,
    .req_valid, .req_ready, .req_op, .req_addr, .req_data, .rsp_valid_reg,
    .rsp_data_reg);
  hostbus_assertions hostbus_assertions_inst (.clk_sys, .rst_n,
    .cmd_type(bus.cmd_type), .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb),
    .bus_mode(bus.bus_mode), .host_mid_oe_n(bus.host_mid_oe_n),
    .dev_mid_oe_n(bus.dev_mid_oe_n), .shared_bus_mid(bus.shared_bus_mid));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic logic sig(int k);
    case (k)
      0: return req_ready;
      1: return addr_valid_reg;
      2: return wr_data_valid_reg;
      default: return rsp_valid_reg;
    endcase
  endfunction

  // Bounded poll; a hang ends the run with a counted failure
  task automatic wait_for(int k);
    int n;
    for (n = 0; n < 20 && sig(k) !== 1'b1; n++) step();
    if (n == 20) begin
      $display("CHECK FAILED at %0t: timeout", $time);
      fails++;
      print_verdict();
    end
  endtask

  task automatic do_req(logic m, host_op_t op, logic [10:2] a, mid_t d);
    mode_16bit = m;
    req_op = op;
    req_addr = a;
    req_data = d;
    rd_data = d;
    wait_for(0);
    req_valid = 1'b1;
    step();
    req_valid = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    mode_16bit = 1'b1;
    req_valid = 1'b0;
    req_op = OP_ADDR;
    req_addr = '0;
    req_data = MID_ZERO;
    rd_data = MID_ZERO;
    repeat (20) step();
    rst_n = 1'b1;
    foreach (rows[i]) begin
      do_req(rows[i].m, rows[i].op, rows[i].a, rows[i].d);
      wait_for(int'(rows[i].op) + 1);
      case (rows[i].op)
        OP_ADDR: got = rows[i].m ? {1'b0, addr_mid_reg}
                                 : {addr_ten_reg, 1'b0, addr_mid_reg[7:2]};
        OP_DATA_WR: got = {1'b0, wr_data_reg};
        default: got = {1'b0, rsp_data_reg};
      endcase
      `CHK(got, rows[i].e)
      `CHK(addr_phase_reg, ADDR_FIRST)
    end
    // Back-to-back 8-bit addresses, the second overwriting the first
    do_req(1'b0, OP_ADDR, 9'h0A4, MID_ZERO);
    step();
    `CHK(addr_phase_reg, ADDR_SECOND)
    do_req(1'b0, OP_ADDR, 9'h1D5, MID_ZERO);
    // The first address completes as the second is taken
    `CHK(addr_valid_reg, 1'b1)
    `CHK({addr_ten_reg, 1'b0, addr_mid_reg[7:2]}, 8'h24)
    step();
    wait_for(1);
    `CHK({addr_ten_reg, 1'b0, addr_mid_reg[7:2]}, 8'h95)
    // Reset landing between the two address writes
    do_req(1'b0, OP_ADDR, 9'h1FF, MID_ZERO);
    step();
    `CHK(addr_phase_reg, ADDR_SECOND)
    rst_n = 1'b0;
    repeat (2) step();
    `CHK(addr_phase_reg, ADDR_FIRST)
    `CHK(addr_mid_reg, MID_ZERO)
    `CHK(bus.cmd_type, CMD_DATA)
    `CHK(bus.host_mid_oe_n, MID_RELEASED)
    rst_n = 1'b1;
    repeat (3) step();
    `CHK(bus.shared_bus_mid[MID_HI], 1'b0)
    print_verdict();
  end
endmodule // tb_top
